// ---- src/adcr_params.svh ----
`ifndef ADCR_PARAMS_SVH
`define ADCR_PARAMS_SVH

// ----------------------------------------------------------------
// Result and frame layout
// ----------------------------------------------------------------
`define ADCR_RESULT_W 16
`define ADCR_PULSE_W 5
`define ADCR_PULSE_SYNC 5'h01
`define ADCR_PULSE_MSB 5'h02
`define ADCR_PULSE_LSB 5'h11
`define ADCR_PULSE_TAG 5'h12

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ADCR_CLK_PERIOD_NS 20
`define ADCR_BUSY_DLY_NS 83
`define ADCR_SYNC_LATENCY 3
`define ADCR_CONV_CYCLES 250

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ADCR_RST_BUSY_N 1'h1
`define ADCR_RST_OUT 1'h0

`endif

// ---- src/adcr_pkg.sv ----
package adcr_pkg;

  // ----------------------------------------------------------------
  // Host pins, travelling together through the synchroniser
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic rd_conv;
    logic sclk;
    logic src_sel;
    logic daisy;
  } adcr_pins_t;

  // ----------------------------------------------------------------
  // Readout sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCR_IDLE,
    ADCR_ARMED,
    ADCR_SHIFT
  } adcr_state_t;

endpackage

// ---- src/adcr_conv.sv ----
`timescale 1ns/1ns
`include "adcr_params.svh"

module adcr_conv
  import adcr_pkg::*;
#(
  parameter int unsigned RES_W = `ADCR_RESULT_W,
  parameter int unsigned CONV_CYCLES = `ADCR_CONV_CYCLES
) (
  // Clock and synchronised reset
  input wire logic clk,
  input wire logic rst_n,
  // Start request and analog sample
  input wire logic start,
  input wire logic [RES_W-1:0] sample_data,
  // Conversion state and last finished result
  output logic busy_n,
  output logic [RES_W-1:0] result
);

  localparam int unsigned CNT_W = $clog2(CONV_CYCLES + 1);

  // Elaboration check: the timer needs one load and one count cycle
  if (CONV_CYCLES < 2) begin
    $error("adcr_conv: CONV_CYCLES must be at least 2");
  end

  logic [CNT_W-1:0] cnt_ff;
  logic busy_ff;
  logic [RES_W-1:0] held_ff;
  logic [RES_W-1:0] result_ff;

  // --------------------------------------------------------------
  // Conversion timer
  // --------------------------------------------------------------
  // Start is ignored while busy; a second request cannot cut a run short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= ~`ADCR_RST_BUSY_N;
      cnt_ff <= '0;
    end else if (!busy_ff && start) begin
      busy_ff <= 1'h1;
      cnt_ff <= CNT_W'(CONV_CYCLES - 1);
    end else if (busy_ff) begin
      if (cnt_ff == '0) begin
        busy_ff <= 1'h0;
      end else begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  // Sample held at start, published only when the run finishes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_ff <= '0;
      result_ff <= '0;
    end else begin
      if (!busy_ff && start) begin
        held_ff <= sample_data;
      end
      if (busy_ff && cnt_ff == '0) begin
        result_ff <= held_ff;
      end
    end
  end

  assign busy_n = ~busy_ff;
  assign result = result_ff;

endmodule

// ---- src/adcr_readout.sv ----
`timescale 1ns/1ns
`include "adcr_params.svh"

// Behaviour
// - Data-clock edge with cs high or convert arms
// - After busy ends, read result while reading
// - Sync launched after rising edge of pulse one
// - Sync valid through pulse one to two
// - MSB at pulse two, one bit per pulse
// - LSB valid through pulse seventeen to eighteen
// - After pulse eighteen, output daisy level from two
// - Convert request drops busy within 83 ns
// - Read during conversion gives previous result
module adcr_readout
  import adcr_pkg::*;
#(
  parameter int unsigned RES_W = `ADCR_RESULT_W,
  parameter int unsigned CONV_CYCLES = `ADCR_CONV_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host control pins
  input wire logic cs_n,
  input wire logic rd_conv,
  input wire logic serial_data_clock,
  input wire logic clock_source_select,
  input wire logic daisy_in,
  // Analog core sample
  input wire logic [RES_W-1:0] sample_data,
  // Serial result pins
  output logic busy_n,
  output logic data_out,
  output logic sync_out
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int unsigned BUSY_DLY_CYC = `ADCR_BUSY_DLY_NS / `ADCR_CLK_PERIOD_NS;
  localparam int unsigned FRAME_BITS = int'(`ADCR_PULSE_LSB) - int'(`ADCR_PULSE_MSB) + 1;

  if (RES_W != FRAME_BITS) begin
    $error("adcr_readout: RES_W must match the frame bit count");
  end
  if (BUSY_DLY_CYC < `ADCR_SYNC_LATENCY) begin
    $error("adcr_readout: clock too slow for the busy delay");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_n_ff;

  // Asynchronous assert, release through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'h0;
      rst_n_ff <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge finding
  // ----------------------------------------------------------------
  adcr_pins_t pins_raw;
  adcr_pins_t pins_meta_ff;
  adcr_pins_t pins_ff;
  adcr_pins_t prev_ff;

  assign pins_raw = '{cs_n: cs_n, rd_conv: rd_conv, sclk: serial_data_clock,
                      src_sel: clock_source_select, daisy: daisy_in};

  // Two flops per pin, then prev_ff for edge finding; the first stage feeds no logic
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pins_meta_ff <= '{cs_n: 1'h1, rd_conv: 1'h1, default: 1'h0};
      pins_ff <= '{cs_n: 1'h1, rd_conv: 1'h1, default: 1'h0};
      prev_ff <= '{cs_n: 1'h1, rd_conv: 1'h1, default: 1'h0};
    end else begin
      pins_meta_ff <= pins_raw;
      pins_ff <= pins_meta_ff;
      prev_ff <= pins_ff;
    end
  end

  logic sclk_edge;
  logic sclk_rise;
  logic arm_cond;
  logic read_cond;
  logic ext_mode;
  logic conv_req;

  // The data clock is slow enough (>= 8 samples a period) to edge-detect
  assign sclk_edge = pins_ff.sclk ^ prev_ff.sclk;
  assign sclk_rise = pins_ff.sclk & ~prev_ff.sclk;
  assign ext_mode = pins_ff.src_sel;
  assign arm_cond = pins_ff.cs_n | (~pins_ff.cs_n & ~pins_ff.rd_conv);
  assign read_cond = ~pins_ff.cs_n & pins_ff.rd_conv;
  // Convert request: read_convert falls with chip select low
  assign conv_req = ~pins_ff.cs_n & prev_ff.rd_conv & ~pins_ff.rd_conv;

  // ----------------------------------------------------------------
  // Conversion engine
  // ----------------------------------------------------------------
  logic [RES_W-1:0] last_result;

  // Three clk edges from pin to busy low, within the 83 ns budget
  adcr_conv #(
    .RES_W(RES_W),
    .CONV_CYCLES(CONV_CYCLES)
  ) u_conv (
    .clk(clk),
    .rst_n(rst_n_ff),
    .start(conv_req),
    .sample_data(sample_data),
    .busy_n(busy_n),
    .result(last_result)
  );

  // ----------------------------------------------------------------
  // Readout sequencer
  // ----------------------------------------------------------------
  adcr_state_t state_ff;
  adcr_state_t nxt_state;
  logic [`ADCR_PULSE_W-1:0] pulse_ff;
  logic [`ADCR_PULSE_W-1:0] nxt_pulse;
  logic step;

  // A pulse in the frame counts only while reading is enabled
  assign step = ext_mode & sclk_rise & read_cond;

  always_comb begin
    nxt_state = state_ff;
    nxt_pulse = pulse_ff;
    unique case (state_ff)
      ADCR_IDLE: begin
        if (ext_mode && sclk_edge && arm_cond) begin
          nxt_state = ADCR_ARMED;
        end
      end
      ADCR_ARMED: begin
        if (!ext_mode) begin
          nxt_state = ADCR_IDLE;
        end else if (step) begin
          nxt_state = ADCR_SHIFT;
          nxt_pulse = `ADCR_PULSE_SYNC;
        end
      end
      ADCR_SHIFT: begin
        if (!ext_mode) begin
          nxt_state = ADCR_IDLE;
        end else if (sclk_edge && arm_cond) begin
          // Chip select high or a new convert ends the frame and re-arms
          nxt_state = ADCR_ARMED;
        end else if (step && pulse_ff != `ADCR_PULSE_TAG) begin
          nxt_pulse = pulse_ff + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= ADCR_IDLE;
      pulse_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      pulse_ff <= nxt_pulse;
    end
  end

  logic frame_step;
  logic frame_start;

  assign frame_start = (state_ff == ADCR_ARMED) && (nxt_state == ADCR_SHIFT);
  assign frame_step = (state_ff == ADCR_SHIFT) && (nxt_state == ADCR_SHIFT) && step;

  // ----------------------------------------------------------------
  // Frame sync
  // ----------------------------------------------------------------
  // High from pulse one rise to pulse two rise
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sync_out <= `ADCR_RST_OUT;
    end else if (frame_start) begin
      sync_out <= 1'h1;
    end else if (frame_step || nxt_state != ADCR_SHIFT) begin
      sync_out <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Result shifter and daisy capture
  // ----------------------------------------------------------------
  logic [RES_W-1:0] shift_ff;
  logic tag_ff;

  // Loaded at pulse one: during a conversion last_result is still n-1
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      shift_ff <= '0;
    end else if (frame_start) begin
      shift_ff <= last_result;
    end else if (frame_step && nxt_pulse > `ADCR_PULSE_MSB && nxt_pulse <= `ADCR_PULSE_LSB) begin
      shift_ff <= {shift_ff[RES_W-2:0], 1'b0};
    end
  end

  // Daisy level seen at the rising edge of pulse two
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      tag_ff <= `ADCR_RST_OUT;
    end else if (frame_step && nxt_pulse == `ADCR_PULSE_MSB) begin
      tag_ff <= pins_ff.daisy;
    end
  end

  // ----------------------------------------------------------------
  // Serial data pin
  // ----------------------------------------------------------------
  // Bits pass MSB first; after the LSB the daisy level follows
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      data_out <= `ADCR_RST_OUT;
    end else if (frame_step) begin
      if (nxt_pulse == `ADCR_PULSE_TAG) begin
        data_out <= tag_ff;
      end else if (nxt_pulse == `ADCR_PULSE_MSB) begin
        data_out <= shift_ff[RES_W-1];
      end else if (nxt_pulse <= `ADCR_PULSE_LSB) begin
        data_out <= shift_ff[RES_W-2];
      end
    end
  end

endmodule

// ---- test/adcr_checker.sv ----
`timescale 1ns/1ns
module adcr_checker
  import adcr_pkg::*;
#(
  parameter int unsigned RES_W = 16,
  parameter int unsigned CONV_CYCLES = 250
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Host pins
  input wire logic cs_n,
  input wire logic rd_conv,
  input wire logic serial_data_clock,
  input wire logic clock_source_select,
  input wire logic daisy_in,
  input wire logic [RES_W-1:0] sample_data,
  // Device pins
  input wire logic busy_n,
  input wire logic data_out,
  input wire logic sync_out
);
  // ----------------------------------------
  // Reset age; pins are seen late after release
  // ----------------------------------------
  logic [2:0] age_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age_ff <= 3'h0;
    end else if (age_ff != 3'h7) begin
      age_ff <= age_ff + 3'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Outputs move three edges after a data-clock rise
  sequence s_rise3;
    $past(serial_data_clock, 3) && !$past(serial_data_clock, 4);
  endsequence
  sequence s_sync_hold;
    sync_out[*7] ##[1:2] !sync_out;
  endsequence
  property p_busy_fall;
    (age_ff == 3'h7 && busy_n && !cs_n && $fell(rd_conv)) |-> ##[1:4] !busy_n;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy late");
  property p_busy_cause;
    $fell(busy_n) |-> !$past(rd_conv, 2) && !$past(cs_n, 2);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy no cause");
  property p_sync_edge;
    $rose(sync_out) |-> s_rise3;
  endproperty
  a_sync_edge: assert property (p_sync_edge) else $error("sync off edge");
  property p_sync_width;
    $rose(sync_out) |-> s_sync_hold;
  endproperty
  a_sync_width: assert property (p_sync_width) else $error("sync width");
  property p_data_step;
    ($changed(data_out) && !$past(cs_n, 3) && $past(rd_conv, 3)) |-> s_rise3;
  endproperty
  a_data_step: assert property (p_data_step) else $error("data off edge");
  property p_sync_sel;
    $rose(sync_out) |-> $past(clock_source_select, 3);
  endproperty
  a_sync_sel: assert property (p_sync_sel) else $error("sync in int mode");
  property p_sync_read;
    $rose(sync_out) |-> !$past(cs_n, 3) && $past(rd_conv, 3);
  endproperty
  a_sync_read: assert property (p_sync_read) else $error("sync not reading");
  property p_sync_gap;
    $fell(sync_out) |-> !sync_out[*8];
  endproperty
  a_sync_gap: assert property (p_sync_gap) else $error("sync in frame");
endmodule

bind adcr_readout adcr_checker #(.RES_W(RES_W), .CONV_CYCLES(CONV_CYCLES)) chk_u (
  .clk(clk),
  .arst_n(arst_n),
  .cs_n(cs_n),
  .rd_conv(rd_conv),
  .serial_data_clock(serial_data_clock),
  .clock_source_select(clock_source_select),
  .daisy_in(daisy_in),
  .sample_data(sample_data),
  .busy_n(busy_n),
  .data_out(data_out),
  .sync_out(sync_out)
);

// ---- test/adcr_host_model.sv ----
`timescale 1ns/1ns
module adcr_host_model (
  // Continuous host data clock
  output logic serial_data_clock
);
  // Free running, 160 ns, phase kept off the system clock edges
  // Runs through conversions: continuous mode accepts that noise cost
  initial begin
    serial_data_clock = 1'b0;
    #7;
    forever #80 serial_data_clock = ~serial_data_clock;
  end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module testbench import adcr_pkg::*;;
  logic clk, arst_n, cs_n, rd_conv, sel, daisy_in, busy_n, dout, sync;
  wire logic dclk;
  logic [15:0] sample_data;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  // ----------------------------------------
  // Clock, design and host clock
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Conversion long enough that a read begun with it ends in its first half
  adcr_readout #(.CONV_CYCLES(400)) dut_u (.clk(clk), .arst_n(arst_n), .cs_n(cs_n),
    .rd_conv(rd_conv),
    .serial_data_clock(dclk), .clock_source_select(sel), .daisy_in(daisy_in),
    .sample_data(sample_data), .busy_n(busy_n), .data_out(dout), .sync_out(sync));
  adcr_host_model host_u (.serial_data_clock(dclk));
  // ----------------------------------------
  // Scenario tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Start a conversion; busy must drop inside 83 ns
  task automatic conv(input logic [15:0] v);
    @(posedge clk);
    sample_data <= v;
    rd_conv <= 1'b0;
    repeat (4) @(posedge clk);
    #1 `CHK("busy_n", 1'b0, busy_n)
  endtask
  task automatic wait_idle;
    int n = 0;
    @(posedge clk) rd_conv <= 1'b1;
    while (busy_n !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    `CHK("busy_end", 1'b1, busy_n)
  endtask
  // Arm, read 18 pulses, daisy level flipped after pulse two
  task automatic frame(input logic [15:0] e, input logic tag, input logic during);
    logic [17:0] cap;
    logic [17:0] s;
    if (!during) begin
      @(posedge clk) cs_n <= 1'b1;
    end
    repeat (2) @(negedge dclk);
    @(posedge clk);
    cs_n <= 1'b0;
    // Set 77 ns before the pulse one rise
    rd_conv <= 1'b1;
    daisy_in <= tag;
    for (int i = 0; i < 18; i++) begin
      @(negedge dclk);
      cap[17-i] = dout;
      s[17-i] = sync;
      if (i == 1) begin
        @(posedge clk) daisy_in <= ~tag;
      end
    end
    `CHK("sync", 18'h20000, s)
    `CHK("msb", e[15], cap[16])
    `CHK("word", e, cap[16:1])
    `CHK("lsb", e[0], cap[1])
    `CHK("daisy", tag, cap[0])
    if (during) begin
      `CHK("busy_mid", 1'b0, busy_n)
    end
  endtask
  // Internal mode: pulses must not start a frame
  task automatic sel_off;
    int hits = 0;
    @(posedge clk);
    sel <= 1'b0;
    cs_n <= 1'b1;
    repeat (2) @(negedge dclk);
    @(posedge clk) cs_n <= 1'b0;
    repeat (6) begin
      @(negedge dclk);
      if (sync !== 1'b0) hits++;
    end
    `CHK("sync_off", 0, hits)
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim;
    end
  end
  // Main sequence
  initial begin
    arst_n = 1'b0;
    cs_n = 1'b0;
    rd_conv = 1'b1;
    sel = 1'b1;
    daisy_in = 1'b0;
    sample_data = 16'h0000;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    conv(16'ha5c3);
    wait_idle;
    frame(16'ha5c3, 1'b1, 1'b0);
    conv(16'h3c5a);
    frame(16'ha5c3, 1'b0, 1'b1);
    wait_idle;
    frame(16'h3c5a, 1'b1, 1'b0);
    sel_off;
    end_sim;
  end
endmodule
